/* verilog/periodic_countdown_timer.sv */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RL1 - While running, count decrements by one every 10 us tick toward zero.
// RL2 - Reload value accepts any 16-bit setting from 1 to 65535.
// RL3 - Reaching zero raises the timer interrupt only if interrupts are allowed.
// RL4 - On zero, counter reloads the stored value and keeps counting.
// RL5 - Software stops the timer before writing a new reload value.
// RL6 - Control bit 0 is run control: 1 counts, 0 stops.
// RL7 - Control bit 1 is interrupt allow: 1 permits, 0 suppresses.
// RL8 - Control bit 2 reads 1 while an interrupt is pending.
// RL9 - Writing 1 to control bit 3 clears the pending interrupt.
// RL10 - Low reload register write stores the reload value's low byte.
// RL11 - High reload register write stores the reload value's high byte.
// RL12 - Low count register read returns the counter's low byte.
// RL13 - High count register read returns the counter's high byte.
// RL14 - Interrupt output high while pending and allowed; pending holds until cleared.
// RL15 - Unused control bits read zero and ignore writes.
module periodic_countdown_timer
  import countdown_timer_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [7:0]        rdata,
  output logic                   irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic        count_run;
    logic        irq_allow;
    logic        irq_pending_flag;
    logic [15:0] reload;
    logic [15:0] count;
    logic [15:0] tick_cnt;
    logic [7:0]  rdata;
    logic        irq;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic   tick;
  logic   wrap;
  logic   clr_hit;

  always_comb
  begin
    nxt_st  = st_ff;
    tick    = 1'b0;
    wrap    = 1'b0;
    clr_hit = wr_stb && addr == OFF_CTRL_STATUS && wdata[BIT_IRQ_CLEAR];

    // Tick prescaler restarts when stopped so the first tick is a full period
    if (!st_ff.count_run)
    begin
      nxt_st.tick_cnt = 16'h0000;
    end
    else if (st_ff.tick_cnt == 16'(TICK_LEN - 1))
    begin
      nxt_st.tick_cnt = 16'h0000;
      tick            = 1'b1;
    end
    else
    begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 16'h0001;
    end

    if (tick)
    begin
      if (st_ff.count <= 16'h0001)
      begin
        // A reload of zero would never wrap; it is treated like one tick
        nxt_st.count = st_ff.reload; // RL4
        wrap         = 1'b1;
      end
      else
      begin
        nxt_st.count = st_ff.count - 16'h0001; // RL1
      end
    end

    if (wr_stb)
    begin
      case (addr)
        OFF_CTRL_STATUS:
        begin
          nxt_st.count_run = wdata[BIT_COUNT_RUN]; // RL6
          nxt_st.irq_allow = wdata[BIT_IRQ_ALLOW]; // RL7
        end
        OFF_RELOAD_LOW:
        begin
          nxt_st.reload[7:0] = wdata; // RL10
          if (!st_ff.count_run)
          begin
            nxt_st.count[7:0] = wdata; // RL5
          end
        end
        OFF_RELOAD_HIGH:
        begin
          nxt_st.reload[15:8] = wdata; // RL11
          if (!st_ff.count_run)
          begin
            nxt_st.count[15:8] = wdata; // RL5
          end
        end
        default:
        begin
        end
      endcase
    end

    // Set wins over a clear in the same cycle
    if (wrap && st_ff.irq_allow)
    begin
      nxt_st.irq_pending_flag = 1'b1; // RL3
    end
    else if (clr_hit)
    begin
      nxt_st.irq_pending_flag = 1'b0; // RL9
    end

    nxt_st.irq = nxt_st.irq_pending_flag && nxt_st.irq_allow; // RL14

    nxt_st.rdata = 8'h00;
    if (rd_stb)
    begin
      case (addr)
        OFF_CTRL_STATUS:
          nxt_st.rdata = {4'h0, st_ff.irq_pending_flag, st_ff.irq_allow,
                          st_ff.count_run}; // RL8 RL15
        OFF_COUNT_LOW:  nxt_st.rdata = st_ff.count[7:0];  // RL12
        OFF_COUNT_HIGH: nxt_st.rdata = st_ff.count[15:8]; // RL13
        default:        nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= '{count_run: 1'b0, irq_allow: 1'b0, irq_pending_flag: 1'b0,
                 reload: RST_RELOAD, count: RST_COUNT, tick_cnt: 16'h0000,
                 rdata: 8'h00, irq: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign irq   = st_ff.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_dec;
    @(posedge sys_clk) disable iff (!rstn)
    tick && st_ff.count > 16'h0001 |=> st_ff.count == $past(st_ff.count) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("count did not decrement"); // RL1

  property p_reload;
    @(posedge sys_clk) disable iff (!rstn)
    wrap && !wr_stb |=> st_ff.count == $past(st_ff.reload);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at zero"); // RL4

  property p_set;
    @(posedge sys_clk) disable iff (!rstn)
    wrap && st_ff.irq_allow |=> st_ff.irq_pending_flag;
  endproperty
  a_set: assert property (p_set) else $error("pending not set"); // RL3

  property p_noset;
    @(posedge sys_clk) disable iff (!rstn)
    !st_ff.irq_pending_flag && !(wrap && st_ff.irq_allow) |=> !st_ff.irq_pending_flag;
  endproperty
  a_noset: assert property (p_noset) else $error("pending set spuriously"); // RL7

  property p_clear;
    @(posedge sys_clk) disable iff (!rstn)
    clr_hit && !wrap |=> !st_ff.irq_pending_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed"); // RL9

  property p_stop;
    @(posedge sys_clk) disable iff (!rstn)
    !st_ff.count_run && !wr_stb |=> $stable(st_ff.count);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped"); // RL6

  property p_irq;
    @(posedge sys_clk) disable iff (!rstn)
    ##1 irq == (st_ff.irq_pending_flag && st_ff.irq_allow);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch"); // RL14

  property p_rd_ctrl;
    @(posedge sys_clk) disable iff (!rstn)
    rd_stb && addr == OFF_CTRL_STATUS |=> rdata[7:3] == 5'h00
      && rdata[2] == $past(st_ff.irq_pending_flag);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("ctrl readback wrong"); // RL8

  property p_rd_hi;
    @(posedge sys_clk) disable iff (!rstn)
    rd_stb && addr == OFF_COUNT_HIGH |=> rdata == $past(st_ff.count[15:8]);
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("count high wrong"); // RL13

  property p_rd_lo;
    @(posedge sys_clk) disable iff (!rstn)
    rd_stb && addr == OFF_COUNT_LOW |=> rdata == $past(st_ff.count[7:0]);
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("count low wrong"); // RL12

  property p_rd_other;
    @(posedge sys_clk) disable iff (!rstn)
    rd_stb && addr != OFF_CTRL_STATUS && addr != OFF_COUNT_LOW && addr != OFF_COUNT_HIGH
      |=> rdata == 8'h00;
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("unmapped read not zero"); // RL10

  property p_rd_idle;
    @(posedge sys_clk) disable iff (!rstn)
    !rd_stb |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data left standing"); // RL12

  property p_run_wr;
    @(posedge sys_clk) disable iff (!rstn)
    wr_stb && addr == OFF_CTRL_STATUS |=> st_ff.count_run == $past(wdata[BIT_COUNT_RUN]);
  endproperty
  a_run_wr: assert property (p_run_wr) else $error("run bit not written"); // RL6

  property p_allow_wr;
    @(posedge sys_clk) disable iff (!rstn)
    wr_stb && addr == OFF_CTRL_STATUS |=> st_ff.irq_allow == $past(wdata[BIT_IRQ_ALLOW]);
  endproperty
  a_allow_wr: assert property (p_allow_wr) else $error("allow bit not written"); // RL7

  property p_lo_wr;
    @(posedge sys_clk) disable iff (!rstn)
    wr_stb && addr == OFF_RELOAD_LOW |=> st_ff.reload[7:0] == $past(wdata);
  endproperty
  a_lo_wr: assert property (p_lo_wr) else $error("reload low not stored"); // RL10

  property p_hi_wr;
    @(posedge sys_clk) disable iff (!rstn)
    wr_stb && addr == OFF_RELOAD_HIGH |=> st_ff.reload[15:8] == $past(wdata);
  endproperty
  a_hi_wr: assert property (p_hi_wr) else $error("reload high not stored"); // RL11

  property p_no_tick_hold;
    @(posedge sys_clk) disable iff (!rstn)
    st_ff.count_run && !tick |=> $stable(st_ff.count);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("count moved off tick"); // RL1

  property p_pend_hold;
    @(posedge sys_clk) disable iff (!rstn)
    st_ff.irq_pending_flag && !clr_hit |=> st_ff.irq_pending_flag;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending dropped"); // RL14

  property p_irq_low;
    @(posedge sys_clk) disable iff (!rstn)
    !st_ff.irq_allow |-> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq while not allowed"); // RL7

  property p_tick_bound;
    @(posedge sys_clk) disable iff (!rstn)
    st_ff.tick_cnt < 16'(TICK_LEN);
  endproperty
  a_tick_bound: assert property (p_tick_bound) else $error("prescaler overran"); // RL1

  property p_tick_stop;
    @(posedge sys_clk) disable iff (!rstn)
    !st_ff.count_run |=> st_ff.tick_cnt == 16'h0000;
  endproperty
  a_tick_stop: assert property (p_tick_stop) else $error("prescaler ran while stopped"); // RL6

  property p_wrap_tick;
    @(posedge sys_clk) disable iff (!rstn)
    wrap |-> tick && st_ff.count <= 16'h0001;
  endproperty
  a_wrap_tick: assert property (p_wrap_tick) else $error("wrap off a tick"); // RL4

  property p_noset_off;
    @(posedge sys_clk) disable iff (!rstn)
    wrap && !st_ff.irq_allow && !st_ff.irq_pending_flag |=> !st_ff.irq_pending_flag;
  endproperty
  a_noset_off: assert property (p_noset_off) else $error("pending set while barred"); // RL3

  property p_set_wins;
    @(posedge sys_clk) disable iff (!rstn)
    wrap && st_ff.irq_allow && clr_hit |=> st_ff.irq_pending_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat the set"); // RL9

  property p_rd_run;
    @(posedge sys_clk) disable iff (!rstn)
    rd_stb && addr == OFF_CTRL_STATUS
      |=> rdata[1:0] == {$past(st_ff.irq_allow), $past(st_ff.count_run)};
  endproperty
  a_rd_run: assert property (p_rd_run) else $error("run or allow readback wrong"); // RL6

  property p_wr_count_ign;
    @(posedge sys_clk) disable iff (!rstn)
    wr_stb && (addr == OFF_COUNT_LOW || addr == OFF_COUNT_HIGH) && !st_ff.count_run
      |=> $stable(st_ff.count);
  endproperty
  a_wr_count_ign: assert property (p_wr_count_ign) else $error("count reg took write"); // RL12

  property p_stop_load;
    @(posedge sys_clk) disable iff (!rstn)
    wr_stb && addr == OFF_RELOAD_HIGH && !st_ff.count_run |=> st_ff.count[15:8] == $past(wdata);
  endproperty
  a_stop_load: assert property (p_stop_load) else $error("stopped load missed"); // RL11

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  c_one:   cover property (@(posedge sys_clk) disable iff (!rstn) wrap && st_ff.reload == 16'h0001);
  c_wrap:  cover property (@(posedge sys_clk) disable iff (!rstn) wrap);
  c_irq:   cover property (@(posedge sys_clk) disable iff (!rstn) $rose(irq));
  c_clear: cover property (@(posedge sys_clk) disable iff (!rstn) clr_hit && wrap);

endmodule

`default_nettype wire

/* verilog/countdown_timer_pkg.sv */
package countdown_timer_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int          ADDR_W          = 32;
  localparam logic [31:0] OFF_CTRL_STATUS = 32'hF1600020;
  localparam logic [31:0] OFF_RELOAD_LOW  = 32'hF1600024;
  localparam logic [31:0] OFF_RELOAD_HIGH = 32'hF1600025;
  localparam logic [31:0] OFF_COUNT_LOW   = 32'hF1600026;
  localparam logic [31:0] OFF_COUNT_HIGH  = 32'hF1600027;

  // ----------------------------------------
  // Control/status field positions
  // ----------------------------------------
  localparam int BIT_COUNT_RUN   = 0;
  localparam int BIT_IRQ_ALLOW   = 1;
  localparam int BIT_IRQ_PENDING = 2;
  localparam int BIT_IRQ_CLEAR   = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_RELOAD = 16'h0001;
  localparam logic [15:0] RST_COUNT  = 16'h0001;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int TICK_NS       = 10_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

endpackage

/* verif/periodic_countdown_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module periodic_countdown_timer_tb
  import countdown_timer_pkg::*;
;
  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  // Short tick keeps every period between 8 and 80 cycles
  localparam int TL = 8;
  logic              sys_clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0]        wdata = 8'h00;
  logic              wr_stb = 1'b0;
  logic              rd_stb = 1'b0;
  logic [7:0]        rdata;
  logic              irq;
  logic [31:0]       seed = 32'h5E3E;
  logic [15:0]       v;
  logic [7:0]        d;
  logic [7:0]        e;
  int                n;
  int                mismatches = 0;
  int                tests_run = 0;

  always #10 sys_clk = ~sys_clk;

  periodic_countdown_timer #(.TICK_LEN(TL)) DUT (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .addr    (addr),
    .wdata   (wdata),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb),
    .rdata   (rdata),
    .irq     (irq)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Drive right after an edge, hold to the sampling edge, release there
  task automatic wr(input logic [31:0] a, input logic [7:0] w);
    @(posedge sys_clk);
    addr <= a;
    wdata <= w;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [7:0] r);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    r = rdata;
  endtask

  task automatic load(input logic [15:0] x);
    wr(OFF_RELOAD_LOW, x[7:0]);
    wr(OFF_RELOAD_HIGH, x[15:8]);
  endtask

  task automatic wait_irq(output int k);
    k = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    while (irq !== 1'b1 && k < 1000);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #(20 * 5000);
    mismatches++;
    finish_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(OFF_CTRL_STATUS, d); chk(d, 8'h00);
    rd(OFF_COUNT_LOW, d); chk(d, RST_COUNT[7:0]);
    rd(OFF_COUNT_HIGH, d); chk(d, RST_COUNT[15:8]);
    for (int i = 0; i < 5; i++)
    begin
      seed = lfsr(seed);
      v = (i == 0) ? 16'h0001 : (i == 1) ? 16'hFFFF : (seed[15:0] | 16'h0001);
      load(v);
      rd(OFF_COUNT_LOW, d); chk(d, v[7:0]);
      rd(OFF_COUNT_HIGH, d); chk(d, v[15:8]);
    end
    wr(OFF_COUNT_LOW, ~v[7:0]);
    rd(OFF_COUNT_LOW, d); chk(d, v[7:0]);
    rd(OFF_RELOAD_LOW, d); chk(d, 8'h00);
    rd(32'hF1600021, d); chk(d, 8'h00);
    wr(OFF_CTRL_STATUS, 8'hF4);
    rd(OFF_CTRL_STATUS, d); chk(d, 8'h00);
    // Period must equal reload ticks, one tick included
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      v = (i < 2) ? 16'(i + 1) : 16'(seed[2:0]) + 16'h0003;
      // Stop and drop a pending flag left by the previous round
      wr(OFF_CTRL_STATUS, 8'h08);
      load(v);
      wr(OFF_CTRL_STATUS, 8'h03);
      wait_irq(n); chk(irq, 1'b1);
      chk(n, v * TL);
      rd(OFF_CTRL_STATUS, d); chk(d, 8'h07);
      // Clear lands four edges after the wrap, well before the next one
      wr(OFF_CTRL_STATUS, 8'h0B);
      wait_irq(n); chk(n, v * TL - 4);
    end
    wr(OFF_CTRL_STATUS, 8'h09);
    repeat (int'(v) * TL + 4) @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    rd(OFF_CTRL_STATUS, d); chk(d, 8'h01);
    wr(OFF_CTRL_STATUS, 8'h03);
    wait_irq(n); chk(irq, 1'b1);
    chk(n <= v * TL, 1'b1);
    wr(OFF_CTRL_STATUS, 8'h02);
    @(posedge sys_clk);
    #1;
    chk(irq, 1'b1);
    rd(OFF_CTRL_STATUS, d); chk(d, 8'h06);
    wr(OFF_CTRL_STATUS, 8'h0A);
    @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    rd(OFF_CTRL_STATUS, d); chk(d, 8'h02);
    rd(OFF_COUNT_LOW, e);
    repeat (3 * TL) @(posedge sys_clk);
    #1;
    rd(OFF_COUNT_LOW, d); chk(d, e);
    finish_test();
  end
endmodule

`default_nettype wire
